// [hw/ift_decoder.sv]
`timescale 1ns/10ps
// Summary of operation
// - 24-bit word, 8-bit opcode, operand remainder
// - Only three opcodes span two words
// - Double-word gathers 48 bits before executing
// - Second word upper eight bits are zero
// - Lone second word executes as no-op
// - Plain single-word instruction takes one cycle
// - Taken test or PC change adds no-op
// - Branch, table, return ops take two/three
// - Taken skip: two cycles, three over dword
// - Double-word instructions take exactly two cycles
// - Register ops: direct base, moded source, destination
// - File ops: address, destination file or register zero
// - Bit position from literal or base register
// - Literal ops: base, literal, optional destination
// - Keep C, DC, N, OV, sticky Z flags
module ift_decoder (
    input wire logic core_clk, // Instruction-cycle clock
    input wire logic reset_n, // Async reset
    input wire logic [23:0] instrWord, // Word from program memory
    input wire logic instrValid, // Word present this cycle
    input wire logic skipCond, // Skip test result for current word
    input wire logic aluDone, // Datapath result ready
    input wire logic resCarry, // Result carry
    input wire logic resDigitCarry, // Result digit carry
    input wire logic resNegative, // Result negative
    input wire logic resOverflow, // Result overflow
    input wire logic resZero, // Result zero
    output logic execValid_q, // Instruction issued
    output ift_pkg::ift_class_e opClass_q, // Issued class
    output logic [7:0] opcode_q, // Issued opcode
    output logic [3:0] baseReg_q, // base_operand_reg
    output logic [3:0] srcReg_q, // source_operand_reg
    output logic [1:0] srcMode_q, // Source address modifier
    output logic [3:0] dstReg_q, // dest_operand_reg
    output logic [1:0] dstMode_q, // Destination address modifier
    output logic [12:0] fileAddr_q, // File register address
    output logic fileToRegZero_q, // Result to working_reg_zero
    output logic [3:0] bitPos_q, // Literal bit position
    output logic bitFromReg_q, // Bit position from base register
    output logic [15:0] literal_q, // Literal operand
    output logic [47:0] extWord_q, // Full double-word operand
    output logic secondWordErr_q, // Second word upper bits not zero
    output logic nopCycle_q, // Extra no-op cycle
    output logic pcChange_q, // program_counter altered
    output logic [4:0] flags_q // Status flags
);
    function automatic logic isDw(input logic [7:0] opc);
        return (opc == ift_pkg::OP_CALL_LONG) || (opc == ift_pkg::OP_GOTO_LONG) ||
            (opc == ift_pkg::OP_MOV_DOUBLE);
    endfunction

    function automatic ift_pkg::ift_class_e classOf(input logic [7:0] opc);
        ift_pkg::ift_class_e c;
        c = ift_pkg::CL_CTRL;
        if (opc == ift_pkg::OP_NOP) begin
            c = ift_pkg::CL_NOP;
        end else if (opc[7:4] == ift_pkg::NIB_REG3) begin
            c = ift_pkg::CL_REG3;
        end else if (opc[7:4] == ift_pkg::NIB_LIT) begin
            c = ift_pkg::CL_LIT;
        end else if (opc[7:4] == ift_pkg::NIB_BIT) begin
            c = ift_pkg::CL_BIT;
        end else if (opc[7:4] == ift_pkg::NIB_FILE) begin
            c = ift_pkg::CL_FILE;
        end
        return c;
    endfunction

    function automatic logic [1:0] fixedExtra(input logic [7:0] opc);
        logic [1:0] e;
        e = ift_pkg::EXTRA_NONE;
        if (opc == ift_pkg::OP_RETURN || opc == ift_pkg::OP_RET_INT) begin
            e = ift_pkg::EXTRA_RETURN;
        end else if (opc == ift_pkg::OP_BRANCH || opc == ift_pkg::OP_BRANCH_COMPUTED ||
                opc == ift_pkg::OP_CALL_IND || opc == ift_pkg::OP_GOTO_IND ||
                opc == ift_pkg::OP_TABLE_RD || opc == ift_pkg::OP_TABLE_WR) begin
            e = ift_pkg::EXTRA_BRANCH;
        end
        return e;
    endfunction

    function automatic logic brTaken(input logic [3:0] cc, input logic [4:0] f);
        logic c, n, v, z, t;
        c = f[ift_pkg::FLG_C];
        n = f[ift_pkg::FLG_N];
        v = f[ift_pkg::FLG_OV];
        z = f[ift_pkg::FLG_Z];
        t = 1'b0;
        unique case (cc)
            4'h0, 4'h2: t = c;
            4'h1: t = ~(n ^ v);
            4'h3: t = ~z & ~(n ^ v);
            4'h4: t = c & ~z;
            4'h5: t = z | (n ^ v);
            4'h6: t = ~c | z;
            4'h7: t = 1'b1;
            4'h8, 4'ha: t = ~c;
            4'h9: t = n;
            4'hb: t = ~n;
            4'hc: t = ~v;
            4'hd: t = ~z;
            4'he: t = v;
            4'hf: t = z;
        endcase
        return t;
    endfunction

    ift_pkg::ift_state_e state_q, state_d;
    logic [1:0] nopLeft_q, nopLeft_d;
    logic skipPend_q, skipPend_d;
    logic [23:0] firstWord_q;
    logic [4:0] flagMask_q;
    logic sticky_q;

    wire [7:0] opc = instrWord[ift_pkg::OPC_HI:ift_pkg::OPC_LO];
    wire [3:0] baseField = instrWord[ift_pkg::BASE_HI:ift_pkg::BASE_LO];
    wire [3:0] dstField = instrWord[ift_pkg::DST_HI:ift_pkg::DST_LO];
    wire fileDest = instrWord[ift_pkg::FDEST_BIT];
    wire ift_pkg::ift_class_e cls = classOf(opc);
    wire wordDw = isDw(opc);
    wire inDecode = (state_q == ift_pkg::ST_DECODE);
    wire take = inDecode && instrValid;
    wire takeSingle = take && !wordDw;
    wire condBr = (opc[7:4] == ift_pkg::NIB_COND_BRANCH) && (opc != ift_pkg::OP_BRANCH);
    wire condHit = condBr && brTaken(opc[3:0], flags_q);
    wire skipHit = (opc[7:4] == ift_pkg::NIB_SKIP) && skipCond;
    wire [1:0] extra = fixedExtra(opc) | {1'b0, condHit | skipHit};
    wire aluCls = (cls == ift_pkg::CL_REG3) || (cls == ift_pkg::CL_LIT) || (cls == ift_pkg::CL_FILE);
    wire [4:0] maskNew = !aluCls ? 5'h00 : (opc[ift_pkg::LOGIC_BIT] ? ift_pkg::MASK_NZ : ift_pkg::MASK_ALL);
    wire finishDw = (state_q == ift_pkg::ST_WORD2) && instrValid;
    wire inFlush = (state_q == ift_pkg::ST_FLUSH);
    wire [4:0] resFlags = {resZero, resOverflow, resNegative, resDigitCarry, resCarry};
    wire zNext = sticky_q ? (flags_q[ift_pkg::FLG_Z] & resZero) : resZero;

    always_comb begin
        state_d = state_q;
        nopLeft_d = nopLeft_q;
        skipPend_d = skipPend_q;
        unique case (state_q)
            ift_pkg::ST_DECODE: begin
                if (take && wordDw) begin
                    state_d = ift_pkg::ST_WORD2;
                end else if (take && extra != ift_pkg::EXTRA_NONE) begin
                    state_d = ift_pkg::ST_FLUSH;
                    nopLeft_d = extra;
                    skipPend_d = skipHit;
                end
            end
            ift_pkg::ST_WORD2: begin
                if (instrValid) begin
                    state_d = ift_pkg::ST_DECODE;
                end
            end
            ift_pkg::ST_FLUSH: begin
                skipPend_d = 1'b0;
                if (!(skipPend_q && instrValid && wordDw)) begin
                    nopLeft_d = nopLeft_q - 2'h1;
                    if (nopLeft_q == 2'h1) begin
                        state_d = ift_pkg::ST_DECODE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ift_pkg::ST_DECODE;
            nopLeft_q <= 2'h0;
            skipPend_q <= 1'b0;
            nopCycle_q <= 1'b0;
        end else begin
            state_q <= state_d;
            nopLeft_q <= nopLeft_d;
            skipPend_q <= skipPend_d;
            nopCycle_q <= inFlush;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            execValid_q <= 1'b0;
            opClass_q <= ift_pkg::CL_NOP;
            opcode_q <= 8'h00;
            pcChange_q <= 1'b0;
            firstWord_q <= 24'h000000;
            extWord_q <= 48'h000000000000;
            secondWordErr_q <= 1'b0;
        end else begin
            execValid_q <= takeSingle || finishDw;
            pcChange_q <= (takeSingle && (fixedExtra(opc) != ift_pkg::EXTRA_NONE || condHit)) || finishDw;
            if (take && wordDw) begin
                firstWord_q <= instrWord;
            end
            if (takeSingle) begin
                opClass_q <= cls;
                opcode_q <= opc;
            end else if (finishDw) begin
                opClass_q <= ift_pkg::CL_DWORD;
                opcode_q <= firstWord_q[ift_pkg::OPC_HI:ift_pkg::OPC_LO];
                extWord_q <= {firstWord_q, instrWord};
                secondWordErr_q <= (opc != ift_pkg::OP_NOP);
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            baseReg_q <= 4'h0;
            srcReg_q <= 4'h0;
            srcMode_q <= 2'h0;
            dstReg_q <= 4'h0;
            dstMode_q <= 2'h0;
            fileAddr_q <= 13'h0000;
            fileToRegZero_q <= 1'b0;
            bitPos_q <= 4'h0;
            bitFromReg_q <= 1'b0;
            literal_q <= 16'h0000;
        end else if (takeSingle) begin
            baseReg_q <= baseField;
            srcReg_q <= instrWord[ift_pkg::SRC_HI:ift_pkg::SRC_LO];
            srcMode_q <= instrWord[ift_pkg::SMODE_HI:ift_pkg::SMODE_LO];
            dstReg_q <= (cls == ift_pkg::CL_LIT && opc[ift_pkg::INPLACE_BIT]) ? baseField : dstField;
            dstMode_q <= instrWord[ift_pkg::DMODE_HI:ift_pkg::DMODE_LO];
            fileAddr_q <= instrWord[ift_pkg::FILE_HI:ift_pkg::FILE_LO];
            fileToRegZero_q <= fileDest;
            bitPos_q <= instrWord[ift_pkg::BITPOS_HI:ift_pkg::BITPOS_LO];
            bitFromReg_q <= (cls == ift_pkg::CL_BIT) && instrWord[ift_pkg::BITSEL_BIT];
            literal_q <= {8'h00, instrWord[ift_pkg::LIT_HI:ift_pkg::LIT_LO]};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_q <= ift_pkg::FLAGS_RST;
            flagMask_q <= 5'h00;
            sticky_q <= 1'b0;
        end else begin
            if (takeSingle) begin
                flagMask_q <= maskNew;
                sticky_q <= opc[ift_pkg::CARRY_BIT] && aluCls;
            end
            if (aluDone) begin
                flags_q <= (flags_q & ~flagMask_q) |
                    ({zNext, resFlags[3:0]} & flagMask_q);
            end
        end
    end

    a_dword_wait: assert property (@(posedge core_clk) disable iff (!reset_n)
        take && wordDw |=> !execValid_q ##1 (state_q == ift_pkg::ST_WORD2 || execValid_q))
        else $error("double word issued before second word");
    a_dword_two: assert property (@(posedge core_clk) disable iff (!reset_n)
        take && wordDw ##1 instrValid |=> execValid_q && opClass_q == ift_pkg::CL_DWORD && !nopCycle_q)
        else $error("double word not done in two cycles");
    a_second_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        finishDw && opc != 8'h00 |=> secondWordErr_q)
        else $error("nonzero second word not flagged");
    a_lone_nop: assert property (@(posedge core_clk) disable iff (!reset_n)
        take && opc == 8'h00 |=> execValid_q && opClass_q == ift_pkg::CL_NOP ##1 !nopCycle_q)
        else $error("lone second word not a no-op");
    a_single_one: assert property (@(posedge core_clk) disable iff (!reset_n)
        takeSingle && extra == 2'h0 |=> execValid_q && !pcChange_q ##1 !nopCycle_q)
        else $error("plain instruction took extra cycle");
    a_taken_two: assert property (@(posedge core_clk) disable iff (!reset_n)
        take && condHit |=> execValid_q && pcChange_q ##1 nopCycle_q ##1 !nopCycle_q)
        else $error("taken branch not two cycles");
    a_return_three: assert property (@(posedge core_clk) disable iff (!reset_n)
        take && (opc == 8'h06 || opc == 8'h07) |=> execValid_q ##1 nopCycle_q [*2] ##1 !nopCycle_q)
        else $error("return not three cycles");
    a_skip_dword: assert property (@(posedge core_clk) disable iff (!reset_n)
        take && skipHit ##1 (instrValid && wordDw) |=> nopCycle_q [*2] ##1 !nopCycle_q)
        else $error("skip over double word not three cycles");
    a_file_dest: assert property (@(posedge core_clk) disable iff (!reset_n)
        takeSingle |=> fileToRegZero_q == $past(fileDest))
        else $error("file destination lost");
    a_base_reg: assert property (@(posedge core_clk) disable iff (!reset_n)
        takeSingle |=> baseReg_q == $past(baseField))
        else $error("base register mismatch");
    a_sticky_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        aluDone && sticky_q && flagMask_q[4] && !flags_q[4] |=> !flags_q[4])
        else $error("sticky zero was set");
endmodule

// [hw/ift_pkg.sv]
package ift_pkg;
    localparam int WORD_W = 24;
    localparam int OPC_W = 8;
    localparam int OPC_HI = 23;
    localparam int OPC_LO = 16;
    localparam int BASE_HI = 15;
    localparam int BASE_LO = 12;
    localparam int DST_HI = 11;
    localparam int DST_LO = 8;
    localparam int DMODE_HI = 7;
    localparam int DMODE_LO = 6;
    localparam int SMODE_HI = 5;
    localparam int SMODE_LO = 4;
    localparam int SRC_HI = 3;
    localparam int SRC_LO = 0;
    localparam int FILE_HI = 12;
    localparam int FILE_LO = 0;
    localparam int FDEST_BIT = 13;
    localparam int BITPOS_HI = 11;
    localparam int BITPOS_LO = 8;
    localparam int BITSEL_BIT = 7;
    localparam int LIT_HI = 11;
    localparam int LIT_LO = 4;
    localparam int LOGIC_BIT = 3;
    localparam int CARRY_BIT = 2;
    localparam int INPLACE_BIT = 0;
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_N = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_Z = 4;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [4:0] MASK_ALL = 5'h1f;
    localparam logic [4:0] MASK_NZ = 5'h14;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_CALL_LONG = 8'h02;
    localparam logic [7:0] OP_GOTO_LONG = 8'h04;
    localparam logic [7:0] OP_MOV_DOUBLE = 8'hbe;
    localparam logic [7:0] OP_BRANCH = 8'h37;
    localparam logic [7:0] OP_BRANCH_COMPUTED = 8'h01;
    localparam logic [7:0] OP_CALL_IND = 8'h03;
    localparam logic [7:0] OP_GOTO_IND = 8'h05;
    localparam logic [7:0] OP_TABLE_RD = 8'hba;
    localparam logic [7:0] OP_TABLE_WR = 8'hbb;
    localparam logic [7:0] OP_RETURN = 8'h06;
    localparam logic [7:0] OP_RET_INT = 8'h07;
    localparam logic [3:0] NIB_COND_BRANCH = 4'h3;
    localparam logic [3:0] NIB_REG3 = 4'h4;
    localparam logic [3:0] NIB_LIT = 4'h5;
    localparam logic [3:0] NIB_BIT = 4'ha;
    localparam logic [3:0] NIB_FILE = 4'hc;
    localparam logic [3:0] NIB_SKIP = 4'he;
    localparam logic [1:0] EXTRA_NONE = 2'h0;
    localparam logic [1:0] EXTRA_BRANCH = 2'h1;
    localparam logic [1:0] EXTRA_RETURN = 2'h2;
    typedef enum logic [2:0] {
        ST_DECODE = 3'b001,
        ST_WORD2 = 3'b010,
        ST_FLUSH = 3'b100
    } ift_state_e;
    typedef enum logic [2:0] {
        CL_NOP = 3'h0,
        CL_REG3 = 3'h1,
        CL_FILE = 3'h2,
        CL_BIT = 3'h3,
        CL_LIT = 3'h4,
        CL_CTRL = 3'h5,
        CL_DWORD = 3'h6
    } ift_class_e;
endpackage

// [tb/ift_prog_mem.sv]
`timescale 1ns/10ps
module ift_prog_mem (
    input wire logic core_clk, // Instruction-cycle clock
    input wire logic reset_n, // Async reset
    input wire logic wrEn, // Load one entry
    input wire logic [3:0] wrAddr, // Load address
    input wire logic [24:0] wrData, // Skip outcome and word
    input wire logic start, // Begin fetching at entry 0
    input wire logic [4:0] runLen, // Words to present
    output logic [23:0] instrWord, // Word to the decoder
    output logic instrValid, // Word present
    output logic skipCond // Skip outcome for the word
);
    logic [24:0] mem [16];
    logic [4:0] ptr;
    logic running;
    wire logic [4:0] idx = start ? 5'h00 : ptr;
    wire logic fetch = start || (running && ptr < runLen);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr <= 5'h00;
            running <= 1'b0;
            instrValid <= 1'b0;
            instrWord <= 24'h000000;
            skipCond <= 1'b0;
        end else begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            if (fetch) begin
                instrWord <= mem[idx[3:0]][23:0];
                skipCond <= mem[idx[3:0]][24];
                instrValid <= 1'b1;
                ptr <= idx + 5'h01;
                running <= 1'b1;
            end else begin
                // Idle bus keeps toggling so stale words never look valid
                instrWord <= ~instrWord;
                skipCond <= 1'b0;
                instrValid <= 1'b0;
                running <= 1'b0;
            end
        end
    end
endmodule

// [tb/instruction_format_and_timing_tb_top.sv]
`timescale 1ns/10ps
module instruction_format_and_timing_tb_top;
    logic core_clk, reset_n, wrEn, start, aluDone;
    logic [3:0] wrAddr;
    logic [24:0] wrData;
    logic [4:0] runLen, resIn;
    logic [23:0] instrWord;
    logic instrValid, skipCond, execValid_q, fileToRegZero_q, bitFromReg_q, secondWordErr_q, nopCycle_q, pcChange_q;
    ift_pkg::ift_class_e opClass_q;
    logic [7:0] opcode_q;
    logic [3:0] baseReg_q, srcReg_q, dstReg_q, bitPos_q;
    logic [1:0] srcMode_q, dstMode_q;
    logic [12:0] fileAddr_q;
    logic [15:0] literal_q;
    logic [47:0] extWord_q;
    logic [4:0] flags_q;
    int mismatches, nCompared, cyc, issues, nops, pcs, firstIssue;
    ift_prog_mem i_ift_prog_mem (.core_clk(core_clk), .reset_n(reset_n), .wrEn(wrEn), .wrAddr(wrAddr),
        .wrData(wrData), .start(start), .runLen(runLen), .instrWord(instrWord), .instrValid(instrValid),
        .skipCond(skipCond));
    ift_decoder i_ift_decoder (.core_clk(core_clk), .reset_n(reset_n), .instrWord(instrWord),
        .instrValid(instrValid), .skipCond(skipCond), .aluDone(aluDone), .resCarry(resIn[0]),
        .resDigitCarry(resIn[1]), .resNegative(resIn[2]), .resOverflow(resIn[3]), .resZero(resIn[4]),
        .execValid_q(execValid_q), .opClass_q(opClass_q), .opcode_q(opcode_q), .baseReg_q(baseReg_q),
        .srcReg_q(srcReg_q), .srcMode_q(srcMode_q), .dstReg_q(dstReg_q), .dstMode_q(dstMode_q),
        .fileAddr_q(fileAddr_q), .fileToRegZero_q(fileToRegZero_q), .bitPos_q(bitPos_q),
        .bitFromReg_q(bitFromReg_q),
        .literal_q(literal_q), .extWord_q(extWord_q), .secondWordErr_q(secondWordErr_q),
        .nopCycle_q(nopCycle_q), .pcChange_q(pcChange_q), .flags_q(flags_q));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Issue monitor, sampled mid-cycle where outputs are settled
    always @(negedge core_clk) begin
        cyc++;
        if (execValid_q === 1'b1) begin
            issues++;
            if (firstIssue == 0) begin
                firstIssue = cyc;
            end
        end
        if (nopCycle_q === 1'b1) begin
            nops++;
        end
        if (pcChange_q === 1'b1) begin
            pcs++;
        end
    end
    task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
        nCompared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        nCompared++;
        if (got != exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [24:0] p [4], input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            wrEn <= 1'b1;
            wrAddr <= i[3:0];
            wrData <= p[i];
        end
        @(posedge core_clk);
        wrEn <= 1'b0;
        runLen <= n[4:0];
        start <= 1'b1;
        cyc = 0;
        issues = 0;
        nops = 0;
        pcs = 0;
        firstIssue = 0;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (n + 8) @(posedge core_clk);
    endtask
    task automatic sc_single;
        run('{25'h04012a5, 0, 0, 0}, 1);
        chk_cnt(firstIssue, 3);
        chk_cnt(nops, 0);
        chk_val(48'(opcode_q), 48'h40);
        chk_val(48'(opClass_q), 48'(ift_pkg::CL_REG3));
        chk_val(48'({baseReg_q, srcReg_q, srcMode_q, dstReg_q, dstMode_q}), 48'h158a);
    endtask
    task automatic sc_ctrl;
        logic [7:0] ops [10] = '{8'h37, 8'h01, 8'h03, 8'h05, 8'hba, 8'hbb, 8'h06, 8'h07, 8'h3a, 8'h30};
        int ex [10] = '{1, 1, 1, 1, 1, 1, 2, 2, 1, 0};
        int pc [10] = '{1, 1, 1, 1, -1, -1, 1, 1, 1, 0};
        for (int i = 0; i < 10; i++) begin
            run('{{1'b0, ops[i], 16'h0000}, 25'h0400000, 25'h0400000, 25'h0400000}, 4);
            chk_cnt(issues, 4 - ex[i]);
            chk_cnt(nops, ex[i]);
            if (pc[i] >= 0) begin
                chk_cnt(pcs, pc[i]);
            end
        end
    endtask
    task automatic sc_dword;
        logic [7:0] ops [3] = '{8'h02, 8'h04, 8'hbe};
        for (int i = 0; i < 3; i++) begin
            run('{{1'b0, ops[i], 16'h1234}, 25'h000abcd, 25'h0400000, 0}, 3);
            chk_cnt(firstIssue, 4);
            chk_cnt(issues, 2);
            chk_cnt(nops, 0);
            chk_val(extWord_q, {ops[i], 16'h1234, 24'h00abcd});
            chk_val(48'(secondWordErr_q), 48'h0);
        end
        run('{25'h0021234, 25'h055abcd, 0, 0}, 2);
        chk_val(48'(secondWordErr_q), 48'h1);
        chk_val(48'(opClass_q), 48'(ift_pkg::CL_DWORD));
        chk_val(48'(opcode_q), 48'h02);
    endtask
    task automatic sc_lone;
        run('{25'h000abcd, 0, 0, 0}, 1);
        chk_cnt(issues, 1);
        chk_val(48'(opClass_q), 48'(ift_pkg::CL_NOP));
        chk_cnt(pcs + nops, 0);
    endtask
    task automatic sc_skip;
        run('{25'h1e00000, 25'h0400000, 25'h0400000, 25'h0400000}, 4);
        chk_cnt(issues, 3);
        chk_cnt(nops, 1);
        run('{25'h1e00000, 25'h0020000, 25'h0000000, 25'h0400000}, 4);
        chk_cnt(issues, 2);
        chk_cnt(nops, 2);
        run('{25'h0e00000, 25'h0400000, 0, 0}, 2);
        chk_cnt(issues + nops, 2);
    endtask
    task automatic sc_fields;
        run('{25'h0c02abc, 0, 0, 0}, 1);
        chk_val(48'({fileToRegZero_q, fileAddr_q}), 48'h2abc);
        chk_val(48'(opClass_q), 48'(ift_pkg::CL_FILE));
        run('{25'h0c01abc, 0, 0, 0}, 1);
        chk_val(48'({fileToRegZero_q, fileAddr_q}), 48'h1abc);
        run('{25'h0a03980, 0, 0, 0}, 1);
        chk_val({baseReg_q, bitPos_q, 3'h0, bitFromReg_q}, 48'h391);
        run('{25'h0514ab0, 0, 0, 0}, 1);
        chk_val({baseReg_q, dstReg_q, literal_q}, 48'h4400ab);
        run('{25'h05047b0, 0, 0, 0}, 1);
        chk_val({baseReg_q, dstReg_q, literal_q}, 48'h47007b);
    endtask
    task automatic sc_flags;
        logic [7:0] ops [3] = '{8'h40, 8'h44, 8'h48};
        logic [4:0] res [3] = '{5'h0d, 5'h10, 5'h1f};
        logic [4:0] exp [3] = '{5'h0d, 5'h00, 5'h14};
        for (int i = 0; i < 3; i++) begin
            run('{{1'b0, ops[i], 16'h1234}, 0, 0, 0}, 1);
            @(posedge core_clk);
            aluDone <= 1'b1;
            resIn <= res[i];
            @(posedge core_clk);
            aluDone <= 1'b0;
            repeat (2) @(posedge core_clk);
            chk_val(48'(flags_q), 48'(exp[i]));
        end
    endtask
    task conclude;
        if (mismatches == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        conclude;
    end
    initial begin
        reset_n = 1'b0;
        wrEn = 1'b0;
        wrAddr = 4'h0;
        wrData = 25'h0000000;
        start = 1'b0;
        runLen = 5'h01;
        aluDone = 1'b0;
        resIn = 5'h00;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        sc_single;
        sc_ctrl;
        sc_dword;
        sc_lone;
        sc_skip;
        sc_fields;
        sc_flags;
        conclude;
    end
endmodule
